// File: encpar_consts.svh
/*
  Object indices, subindices, reset values and field positions of the
  encoder parameter object bank.
  Assumes an SDO server upstream that hands over index, subindex and data.
*/
`ifndef ENCPAR_CONSTS_SVH
`define ENCPAR_CONSTS_SVH

// ==========================================================
// object indices
`define ENCPAR_IDX_OPER 16'h2100
`define ENCPAR_IDX_TOTAL 16'h2102
`define ENCPAR_IDX_PRESET 16'h2103
`define ENCPAR_IDX_LIM_MIN 16'h2104
`define ENCPAR_IDX_LIM_MAX 16'h2105
`define ENCPAR_IDX_USER 16'h2160
`define ENCPAR_IDX_CYCLIC 16'h2200
`define ENCPAR_IDX_SAVE 16'h2300
`define ENCPAR_IDX_STATION 16'h3000
`define ENCPAR_IDX_BITRATE 16'h3001
`define ENCPAR_IDX_TERM 16'h3002

// ==========================================================
// reset values and codes
`define ENCPAR_USER_COUNT 8'h04
`define ENCPAR_SAVE_CODE 32'h55AAAA55
`define ENCPAR_STATION_RST 8'h1F
`define ENCPAR_BITRATE_RST 8'h03
`define ENCPAR_TOTAL_RST 32'h01000000
`define ENCPAR_RANGE_ABORT 32'h06090030
`define ENCPAR_NOOBJ_ABORT 32'h06020000
`define ENCPAR_ACCESS_ABORT 32'h06010000

// ==========================================================
// field positions
`define ENCPAR_BIT_MAX 31
`define ENCPAR_BIT_MIN 30
`define ENCPAR_OPER_MIN_EN 1
`define ENCPAR_OPER_MAX_EN 2

`endif

// File: encpar_pkg.sv
/*
  Types of the encoder parameter object bank.
  Assumes encpar_consts.svh for all numeric values except the state encodings defined here.
*/
package encpar_pkg;
  typedef logic [31:0] encpar_word_t;
  typedef logic [15:0] encpar_index_t;
  typedef logic [7:0] encpar_sub_t;
  typedef enum logic [1:0] {ENCPAR_RUN = 2'b00, ENCPAR_SAVE = 2'b01,
                            ENCPAR_RESTART = 2'b11} encpar_state_e;
endpackage : encpar_pkg

// File: encpar_limit.sv
/*
  Limit status evaluation for one transmitted process word.
  Assumes the position arrives already scaled and preset-corrected.
*/
`timescale 1ns/100ps
`include "encpar_consts.svh"
module encpar_limit
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_tx_strobe,
  input wire logic [29:0] i_position,
  input wire logic [31:0] i_lower,
  input wire logic [31:0] i_upper,
  input wire logic i_lower_en,
  input wire logic i_upper_en,
  output logic [31:0] o_word
);
  logic [31:0] word_reg;
  logic [31:0] word_next;
  logic [31:0] pos32;

  always_comb
  begin
    pos32 = {2'b00, i_position};
    word_next = word_reg;
    if (i_tx_strobe)
    begin
      word_next = {2'b00, i_position};
      word_next[`ENCPAR_BIT_MIN] = i_lower_en && (pos32 <= i_lower);
      word_next[`ENCPAR_BIT_MAX] = i_upper_en && (pos32 >= i_upper);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      word_reg <= 32'h0;
    else
      word_reg <= word_next;
  end

  assign o_word = word_reg;
endmodule : encpar_limit

// File: encpar_preset.sv
/*
  Position offset so the current shaft position reads as the preset.
  Assumes raw position below the configured total range.
*/
`timescale 1ns/100ps
module encpar_preset
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic [31:0] i_preset,
  input wire logic [31:0] i_raw,
  input wire logic [31:0] i_range,
  output logic [29:0] o_position
);
  logic [31:0] offset_reg;
  logic [31:0] offset_next;
  logic [31:0] pos_reg;
  logic [31:0] pos_next;
  logic [32:0] sum;

  always_comb
  begin
    offset_next = offset_reg;
    // offset so raw maps to preset
    if (i_load)
    begin
      if (i_preset >= i_raw)
        offset_next = i_preset - i_raw;
      else
        offset_next = i_range - (i_raw - i_preset);
    end
    sum = {1'b0, i_raw} + {1'b0, offset_reg};
    // wraps around the configured range
    if (sum >= {1'b0, i_range})
      pos_next = 32'(sum - {1'b0, i_range});
    else
      pos_next = sum[31:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      offset_reg <= 32'h0;
      pos_reg <= 32'h0;
    end
    else
    begin
      offset_reg <= offset_next;
      pos_reg <= pos_next;
    end
  end

  assign o_position = pos_reg[29:0];
endmodule : encpar_preset

// File: encpar_bank.sv
/*
  Manufacturer parameter object bank of an absolute encoder.
  Assumes an SDO server delivering one-cycle read/write requests with
  index, subindex and data, and consuming an answer registered one cycle later.
*/
`timescale 1ns/100ps
`include "encpar_consts.svh"
module encpar_bank
  import encpar_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_req,
  input wire logic i_write,
  input wire encpar_pkg::encpar_index_t i_index,
  input wire encpar_pkg::encpar_sub_t i_sub,
  input wire encpar_pkg::encpar_word_t i_wdata,
  input wire logic [31:0] i_raw_position,
  input wire logic [15:0] i_event_timer,
  input wire logic i_tx_strobe,
  input wire logic i_save_done,
  output encpar_pkg::encpar_word_t o_rdata,
  output logic o_ack,
  output logic o_abort,
  output encpar_pkg::encpar_word_t o_abort_code,
  output encpar_pkg::encpar_word_t o_process_word,
  output logic [7:0] o_node_id,
  output logic [10:0] o_bit_rate_kbps,
  output logic o_term_on,
  output logic o_save_start,
  output logic o_restart
);
  import encpar_pkg::*;

  // ========================================================
  // parameter storage
  logic [7:0] oper_reg;
  logic [7:0] oper_next;
  encpar_word_t total_reg;
  encpar_word_t total_next;
  encpar_word_t preset_reg;
  encpar_word_t preset_next;
  encpar_word_t lower_reg;
  encpar_word_t lower_next;
  encpar_word_t upper_reg;
  encpar_word_t upper_next;
  encpar_word_t user_reg [4];
  encpar_word_t user_next [4];
  logic [7:0] station_reg;
  logic [7:0] station_next;
  logic [7:0] rate_reg;
  logic [7:0] rate_next;
  logic term_reg;
  logic term_next;
  logic preset_load;
  encpar_word_t rdata_reg;
  encpar_word_t rdata_next;
  logic ack_reg;
  logic abort_reg;
  logic abort_next;
  encpar_word_t code_reg;
  encpar_word_t code_next;
  encpar_state_e state_reg;
  encpar_state_e state_next;
  logic wr;
  logic rd;
  logic user_hit;

  assign wr = i_req && i_write;
  assign rd = i_req && !i_write;
  assign user_hit = (i_index == `ENCPAR_IDX_USER) && (i_sub >= 8'h01) && (i_sub <= 8'h04);

  // ========================================================
  // request decode
  always_comb
  begin
    oper_next = oper_reg;
    total_next = total_reg;
    preset_next = preset_reg;
    lower_next = lower_reg;
    upper_next = upper_reg;
    user_next = user_reg;
    station_next = station_reg;
    rate_next = rate_reg;
    term_next = term_reg;
    preset_load = 1'b0;
    rdata_next = 32'h0;
    abort_next = 1'b0;
    code_next = 32'h0;
    state_next = state_reg;
    unique case (i_index)
      `ENCPAR_IDX_OPER:
      begin
        rdata_next = {24'h0, oper_reg};
        if (wr)
          oper_next = i_wdata[7:0];
      end
      `ENCPAR_IDX_TOTAL:
      begin
        rdata_next = total_reg;
        if (wr)
          total_next = i_wdata;
      end
      `ENCPAR_IDX_PRESET:
      begin
        rdata_next = preset_reg;
        if (wr && (i_wdata >= total_reg))
        begin
          abort_next = 1'b1;
          code_next = `ENCPAR_RANGE_ABORT;
        end
        else if (wr)
        begin
          preset_next = i_wdata;
          preset_load = 1'b1;
        end
      end
      `ENCPAR_IDX_LIM_MIN, `ENCPAR_IDX_LIM_MAX:
      begin
        rdata_next = (i_index == `ENCPAR_IDX_LIM_MIN) ? lower_reg : upper_reg;
        if (wr && (i_wdata >= total_reg))
        begin
          abort_next = 1'b1;
          code_next = `ENCPAR_RANGE_ABORT;
        end
        else if (wr && (i_index == `ENCPAR_IDX_LIM_MIN))
          lower_next = i_wdata;
        else if (wr)
          upper_next = i_wdata;
      end
      `ENCPAR_IDX_USER:
      begin
        if (i_sub == 8'h00)
        begin
          rdata_next = {24'h0, `ENCPAR_USER_COUNT};
          if (wr)
          begin
            abort_next = 1'b1;
            code_next = `ENCPAR_ACCESS_ABORT;
          end
        end
        else if (user_hit)
        begin
          rdata_next = user_reg[2'(i_sub - 8'h01)];
          if (wr)
            user_next[2'(i_sub - 8'h01)] = i_wdata;
        end
        else
        begin
          abort_next = 1'b1;
          code_next = `ENCPAR_NOOBJ_ABORT;
        end
      end
      `ENCPAR_IDX_CYCLIC:
      begin
        rdata_next = {16'h0, i_event_timer};
        if (wr)
        begin
          abort_next = 1'b1;
          code_next = `ENCPAR_ACCESS_ABORT;
        end
      end
      `ENCPAR_IDX_SAVE:
      begin
        // write-only: reads abort
        if (rd)
        begin
          abort_next = 1'b1;
          code_next = `ENCPAR_ACCESS_ABORT;
        end
        else if (wr && (i_wdata == `ENCPAR_SAVE_CODE) && (state_reg == ENCPAR_RUN))
          state_next = ENCPAR_SAVE;
        else if (wr && (i_wdata != `ENCPAR_SAVE_CODE))
        begin
          abort_next = 1'b1;
          code_next = `ENCPAR_RANGE_ABORT;
        end
      end
      `ENCPAR_IDX_STATION:
      begin
        rdata_next = {24'h0, station_reg};
        if (wr)
          station_next = i_wdata[7:0];
      end
      `ENCPAR_IDX_BITRATE:
      begin
        rdata_next = {24'h0, rate_reg};
        if (wr && (i_wdata[7:0] > 8'h07))
        begin
          abort_next = 1'b1;
          code_next = `ENCPAR_RANGE_ABORT;
        end
        else if (wr)
          rate_next = i_wdata[7:0];
      end
      `ENCPAR_IDX_TERM:
      begin
        rdata_next = {31'h0, term_reg};
        if (wr)
          term_next = i_wdata[0];
      end
      default:
      begin
        abort_next = 1'b1;
        code_next = `ENCPAR_NOOBJ_ABORT;
      end
    endcase
    if (!i_req)
    begin
      abort_next = 1'b0;
      code_next = 32'h0;
      rdata_next = 32'h0;
    end
    // save then restart once storage reports done
    if ((state_reg == ENCPAR_SAVE) && i_save_done)
      state_next = ENCPAR_RESTART;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      oper_reg <= 8'h00;
      total_reg <= `ENCPAR_TOTAL_RST;
      preset_reg <= 32'h0;
      lower_reg <= 32'h0;
      upper_reg <= 32'h0;
      station_reg <= `ENCPAR_STATION_RST;
      rate_reg <= `ENCPAR_BITRATE_RST;
      term_reg <= 1'b0;
      rdata_reg <= 32'h0;
      ack_reg <= 1'b0;
      abort_reg <= 1'b0;
      code_reg <= 32'h0;
      state_reg <= ENCPAR_RUN;
    end
    else
    begin
      oper_reg <= oper_next;
      total_reg <= total_next;
      preset_reg <= preset_next;
      lower_reg <= lower_next;
      upper_reg <= upper_next;
      station_reg <= station_next;
      rate_reg <= rate_next;
      term_reg <= term_next;
      rdata_reg <= rdata_next;
      ack_reg <= i_req;
      abort_reg <= abort_next;
      code_reg <= code_next;
      state_reg <= state_next;
    end
  end

  // volatile: no reset, content lost on power loss anyway
  always_ff @(posedge i_clk)
  begin
    user_reg <= user_next;
  end

  // ========================================================
  // position path
  logic [29:0] position;

  encpar_preset u_preset
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_load(preset_load),
    .i_preset(i_wdata),
    .i_raw(i_raw_position),
    .i_range(total_reg),
    .o_position(position)
  );

  encpar_limit u_limit
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_tx_strobe(i_tx_strobe),
    .i_position(position),
    .i_lower(lower_reg),
    .i_upper(upper_reg),
    .i_lower_en(oper_reg[`ENCPAR_OPER_MIN_EN]),
    .i_upper_en(oper_reg[`ENCPAR_OPER_MAX_EN]),
    .o_word(o_process_word)
  );

  // ========================================================
  // bus settings
  always_comb
  begin
    unique case (rate_reg[2:0])
      3'h0: o_bit_rate_kbps = 11'd20;
      3'h1: o_bit_rate_kbps = 11'd50;
      3'h2: o_bit_rate_kbps = 11'd100;
      3'h3: o_bit_rate_kbps = 11'd125;
      3'h4: o_bit_rate_kbps = 11'd250;
      3'h5: o_bit_rate_kbps = 11'd500;
      3'h6: o_bit_rate_kbps = 11'd800;
      3'h7: o_bit_rate_kbps = 11'd1000;
    endcase
  end

  assign o_node_id = station_reg + 8'h01;
  assign o_term_on = term_reg;
  assign o_save_start = (state_reg == ENCPAR_SAVE);
  assign o_restart = (state_reg == ENCPAR_RESTART);
  assign o_rdata = rdata_reg;
  assign o_ack = ack_reg;
  assign o_abort = abort_reg;
  assign o_abort_code = code_reg;
endmodule : encpar_bank

// File: encpar_bank_props.sv
/*
  Port assertions for the encoder parameter bank.
  Assumes a bind from the bench top and the default total range.
*/
`timescale 1ns/100ps
`include "encpar_consts.svh"
module encpar_bank_props
  import encpar_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_req,
  input wire logic i_write,
  input wire encpar_pkg::encpar_index_t i_index,
  input wire encpar_pkg::encpar_sub_t i_sub,
  input wire encpar_pkg::encpar_word_t i_wdata,
  input wire logic [15:0] i_event_timer,
  input wire logic i_tx_strobe,
  input wire logic i_save_done,
  input wire encpar_pkg::encpar_word_t o_rdata,
  input wire logic o_abort,
  input wire encpar_pkg::encpar_word_t o_abort_code,
  input wire encpar_pkg::encpar_word_t o_process_word,
  input wire logic [7:0] o_node_id,
  input wire logic [10:0] o_bit_rate_kbps,
  input wire logic o_term_on,
  input wire logic o_save_start,
  input wire logic o_restart
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  // ==========================================================
  // object answers
  property p_node;
    i_req && i_write && i_index == `ENCPAR_IDX_STATION
      |=> o_node_id == $past(i_wdata[7:0]) + 8'h01;
  endproperty
  a_node: assert property (p_node) else $error("node id not stored plus one");
  property p_rate;
    o_bit_rate_kbps inside {20, 50, 100, 125, 250, 500, 800, 1000};
  endproperty
  a_rate: assert property (p_rate) else $error("bit rate outside table");
  property p_term;
    i_req && i_write && i_index == `ENCPAR_IDX_TERM |=> o_term_on == $past(i_wdata[0]);
  endproperty
  a_term: assert property (p_term) else $error("termination not following");
  property p_cyclic;
    i_req && !i_write && i_index == `ENCPAR_IDX_CYCLIC
      |=> o_rdata == {16'h0000, $past(i_event_timer)};
  endproperty
  a_cyclic: assert property (p_cyclic) else $error("cyclic mirror differs");
  property p_count;
    i_req && !i_write && i_index == `ENCPAR_IDX_USER && i_sub == 8'h00
      |=> o_rdata == 32'h00000004;
  endproperty
  a_count: assert property (p_count) else $error("user count wrong");
  property p_range;
    i_req && i_write && i_wdata >= `ENCPAR_TOTAL_RST && i_index inside
      {`ENCPAR_IDX_PRESET, `ENCPAR_IDX_LIM_MIN, `ENCPAR_IDX_LIM_MAX}
      |=> o_abort && o_abort_code == `ENCPAR_RANGE_ABORT;
  endproperty
  a_range: assert property (p_range) else $error("out of range not refused");
  // ==========================================================
  // save, restart and process word hold
  property p_bad_code;
    i_req && i_write && i_index == `ENCPAR_IDX_SAVE && i_wdata != `ENCPAR_SAVE_CODE
      && !o_save_start |=> o_abort && !o_save_start ##1 !o_save_start;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("wrong code saved");
  property p_save;
    i_req && i_write && i_index == `ENCPAR_IDX_SAVE && i_wdata == `ENCPAR_SAVE_CODE
      |=> o_save_start;
  endproperty
  a_save: assert property (p_save) else $error("save not started");
  property p_restart;
    o_save_start && i_save_done ##1 1'b1 |-> o_restart [*3];
  endproperty
  a_restart: assert property (p_restart) else $error("restart not held");
  property p_word_hold;
    !i_tx_strobe |=> $stable(o_process_word);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word moved w/o strobe");
endmodule : encpar_bank_props

// File: encpar_master.sv
/*
  SDO master model driving the bank's request port.
  Assumes answers one cycle after the taken edge.
*/
`timescale 1ns/100ps
module encpar_master
(
  input wire logic i_clk,
  input wire logic i_ack,
  input wire logic i_abort,
  input wire logic [31:0] i_rdata,
  input wire logic [31:0] i_abort_code,
  output logic o_req,
  output logic o_write,
  output logic [15:0] o_index,
  output logic [7:0] o_sub,
  output logic [31:0] o_wdata
);
  initial
  begin
    {o_req, o_write, o_index, o_sub, o_wdata} = '0;
  end
  // values as commanded by the bench
  task automatic xfer(input logic w, input logic [15:0] x, input logic [7:0] s,
                      input logic [31:0] d, output logic [31:0] rd, output logic ab);
    @(posedge i_clk);
    o_req <= 1'b1;
    o_write <= w;
    o_index <= x;
    o_sub <= s;
    o_wdata <= d;
    @(posedge i_clk);
    // released index and data scrambled, never left looking valid
    o_req <= 1'b0;
    o_index <= ~x;
    o_wdata <= ~d;
    // answer registered at the take, taken at the edge that samples it
    @(posedge i_clk);
    ab = i_abort;
    rd = i_abort ? i_abort_code : i_rdata;
    if (i_ack !== 1'b1)
      ab = 1'bx;
  endtask : xfer
endmodule : encpar_master

// File: encoder_parameter_objects_tb_top.sv
/*
  Self-checking bench of the encoder parameter bank.
  Assumes the master model and the checker file.
*/
`timescale 1ns/100ps
`include "encpar_consts.svh"
module encoder_parameter_objects_tb_top;
  import encpar_pkg::*;
  logic i_clk, i_reset, i_req, i_write, i_tx_strobe, i_save_done, ab;
  logic o_ack, o_abort, o_term_on, o_save_start, o_restart;
  encpar_index_t i_index;
  encpar_sub_t i_sub;
  encpar_word_t i_wdata, o_rdata, o_abort_code, o_process_word, rd;
  logic [31:0] i_raw_position;
  logic [15:0] i_event_timer;
  logic [7:0] o_node_id;
  logic [10:0] o_bit_rate_kbps;
  int error_cnt = 0;
  int n_checks = 0;
  encpar_bank dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_req(i_req),
    .i_write(i_write), .i_index(i_index), .i_sub(i_sub), .i_wdata(i_wdata),
    .i_raw_position(i_raw_position), .i_event_timer(i_event_timer),
    .i_tx_strobe(i_tx_strobe), .i_save_done(i_save_done), .o_rdata(o_rdata),
    .o_ack(o_ack), .o_abort(o_abort), .o_abort_code(o_abort_code),
    .o_process_word(o_process_word), .o_node_id(o_node_id),
    .o_bit_rate_kbps(o_bit_rate_kbps), .o_term_on(o_term_on),
    .o_save_start(o_save_start), .o_restart(o_restart));
  encpar_master mst_u (.i_clk(i_clk), .i_ack(o_ack), .i_abort(o_abort),
    .i_rdata(o_rdata), .i_abort_code(o_abort_code), .o_req(i_req),
    .o_write(i_write), .o_index(i_index), .o_sub(i_sub), .o_wdata(i_wdata));
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task acc(input logic w, input logic [15:0] x, input logic [7:0] s, input logic [31:0] d);
    mst_u.xfer(w, x, s, d, rd, ab);
    chk("answered", 32'h0, {31'h0, $isunknown(ab)});
  endtask : acc
  task tx;
    @(posedge i_clk);
    i_tx_strobe <= 1'b1;
    @(posedge i_clk);
    i_tx_strobe <= 1'b0;
    #1;
  endtask : tx
  task do_reset;
    i_reset <= 1'b1;
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
  endtask : do_reset
  task test_done;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // ==========================================================
  // scenarios
  task t_defaults;
    acc(0, `ENCPAR_IDX_STATION, 0, 0);
    chk("station", 32'h1F, rd);
    chk("node", 32'h20, {24'h0, o_node_id});
    chk("term", 32'h0, {31'h0, o_term_on});
    chk("rate_rst", 32'd125, {21'h0, o_bit_rate_kbps});
    chk("word_rst", 32'h0, o_process_word);
    acc(0, `ENCPAR_IDX_CYCLIC, 0, 0);
    chk("cyclic", 32'h1234, rd);
    @(posedge i_clk);
    i_event_timer <= 16'hBEEF;
    acc(0, `ENCPAR_IDX_CYCLIC, 0, 0);
    chk("cyclic_new", 32'hBEEF, rd);
    acc(1, `ENCPAR_IDX_CYCLIC, 0, 5);
    chk("cyc_ro", `ENCPAR_ACCESS_ABORT, rd);
    acc(0, `ENCPAR_IDX_USER, 0, 0);
    chk("count", 32'h4, rd);
    acc(0, `ENCPAR_IDX_SAVE, 0, 0);
    chk("save_wo", `ENCPAR_ACCESS_ABORT, rd);
    for (int i = 0; i < 3; i++)
    begin
      acc(0, 16'(`ENCPAR_IDX_PRESET + i), 0, 0);
      chk("zero_rst", 32'h0, rd);
    end
  endtask : t_defaults
  task t_user;
    for (int i = 1; i < 5; i++)
    begin
      acc(1, `ENCPAR_IDX_USER, 8'(i), 32'hA5C30000 + i);
    end
    for (int i = 1; i < 5; i++)
    begin
      acc(0, `ENCPAR_IDX_USER, 8'(i), 0);
      chk("user", 32'hA5C30000 + i, rd);
    end
    acc(1, `ENCPAR_IDX_USER, 0, 7);
    chk("cnt_ro", `ENCPAR_ACCESS_ABORT, rd);
    acc(0, `ENCPAR_IDX_USER, 5, 0);
    chk("sub5", `ENCPAR_NOOBJ_ABORT, rd);
  endtask : t_user
  task t_node_rate;
    int kb [8] = '{20, 50, 100, 125, 250, 500, 800, 1000};
    for (int i = 0; i < 8; i++)
    begin
      acc(1, `ENCPAR_IDX_BITRATE, 0, i);
      chk("rate", kb[i], {21'h0, o_bit_rate_kbps});
    end
    acc(1, `ENCPAR_IDX_BITRATE, 0, 8);
    chk("rate_abort", `ENCPAR_RANGE_ABORT, rd);
    chk("rate_bad", 32'd1000, {21'h0, o_bit_rate_kbps});
    acc(1, `ENCPAR_IDX_STATION, 0, 5);
    chk("node5", 32'h6, {24'h0, o_node_id});
    acc(1, `ENCPAR_IDX_TERM, 0, 1);
    chk("term_on", 32'h1, {31'h0, o_term_on});
    acc(1, `ENCPAR_IDX_TERM, 0, 0);
    chk("term_off", 32'h0, {31'h0, o_term_on});
  endtask : t_node_rate
  task t_limits;
    acc(1, `ENCPAR_IDX_PRESET, 0, `ENCPAR_TOTAL_RST);
    chk("pre_big", `ENCPAR_RANGE_ABORT, rd);
    acc(1, `ENCPAR_IDX_LIM_MAX, 0, 32'hFFFFFFFF);
    chk("lim_big", `ENCPAR_RANGE_ABORT, rd);
    acc(1, `ENCPAR_IDX_PRESET, 0, 32'h500);
    tx;
    chk("preset", 32'h500, o_process_word);
    acc(1, `ENCPAR_IDX_OPER, 0, 6);
    acc(1, `ENCPAR_IDX_LIM_MIN, 0, 32'h500);
    acc(1, `ENCPAR_IDX_LIM_MAX, 0, 32'h501);
    tx;
    chk("at_min", 32'h40000500, o_process_word);
    @(posedge i_clk);
    i_raw_position <= 32'h101;
    tx;
    chk("at_max", 32'h80000501, o_process_word);
    acc(1, `ENCPAR_IDX_OPER, 0, 0);
    tx;
    chk("limit_off", 32'h501, o_process_word);
    acc(1, `ENCPAR_IDX_TOTAL, 0, 32'h1000);
    acc(1, `ENCPAR_IDX_PRESET, 0, 32'h1000);
    chk("pre_total", `ENCPAR_RANGE_ABORT, rd);
    acc(1, `ENCPAR_IDX_LIM_MIN, 0, 32'h1000);
    chk("lim_total", `ENCPAR_RANGE_ABORT, rd);
  endtask : t_limits
  task t_save;
    acc(1, `ENCPAR_IDX_SAVE, 0, 32'h12345678);
    chk("bad_code", `ENCPAR_RANGE_ABORT, rd);
    chk("no_save", 32'h0, {31'h0, o_save_start});
    chk("no_restart", 32'h0, {31'h0, o_restart});
    acc(1, `ENCPAR_IDX_SAVE, 0, `ENCPAR_SAVE_CODE);
    chk("save", 32'h1, {31'h0, o_save_start});
    @(posedge i_clk);
    i_save_done <= 1'b1;
    @(posedge i_clk);
    i_save_done <= 1'b0;
    #1;
    chk("restart", 32'h1, {31'h0, o_restart});
    @(posedge i_clk);
    do_reset;
    #1;
    chk("restart_clr", 32'h0, {31'h0, o_restart});
    chk("node_rst", 32'h20, {24'h0, o_node_id});
    chk("word_clr", 32'h0, o_process_word);
  endtask : t_save
  initial
  begin
    {i_reset, i_tx_strobe, i_save_done} = 3'b100;
    i_raw_position = 32'h100;
    i_event_timer = 16'h1234;
    do_reset;
    t_defaults;
    t_user;
    t_node_rate;
    t_limits;
    t_save;
    test_done;
  end
  initial
  begin
    #1000000;
    error_cnt++;
    test_done;
  end
endmodule : encoder_parameter_objects_tb_top
bind encpar_bank encpar_bank_props props_u (.*);
